/* File: src/bsw_pkg.sv */
package bsw_pkg;
   // ************************************************************
   // Register map (byte addresses; level/enables and control/count pairs each share one aligned word)
   // ************************************************************
   localparam logic [15:0] ADDR_LEVEL_SELECT = 16'hff20;
   localparam logic [15:0] ADDR_ENABLES = 16'hff22;
   localparam logic [15:0] ADDR_FLAGS = 16'hff24;
   localparam logic [15:0] ADDR_CONTROL = 16'hff42;
   localparam logic [15:0] ADDR_COUNT = 16'hff43;
   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int RUN_BIT = 0;
   localparam int CLEAR_BIT = 1;
   localparam int LEVEL_LO = 2;
   localparam int LEVEL_HI = 3;
   localparam int ONE_HZ_BIT = 4;
   localparam int TEN_HZ_BIT = 5;
   localparam int HUNDRED_HZ_BIT = 6;
   // ************************************************************
   // Reset values and timing
   // ************************************************************
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [1:0] LEVEL_RESET = 2'h0;
   localparam logic [2:0] ENABLE_RESET = 3'h0;
   localparam logic [2:0] FLAG_RESET = 3'h0;
   localparam logic [3:0] BCD_MAX = 4'h9;
   localparam int CLK_HZ = 200000000;
   localparam int TICK_HZ = 256;
   localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
   localparam logic [1:0] DIV_SHORT = 2'h2;
   localparam logic [1:0] DIV_LONG = 2'h3;
endpackage

/* File: src/bsw_stopwatch.sv */
`timescale 1ns/1ps
// Notes on behaviour
// R1: Count register: low nibble hundredths, high nibble tenths, both BCD.
// R2: Count register is read-only; writes leave the count untouched.
// R3: Reset clears both count digits.
// R4: Writing one to the clear bit clears both digits.
// R5: Writing zero to clear does nothing; clear bit reads zero.
// R6: Clear while running resumes counting from zero at once.
// R7: Clear while stopped holds zero until restarted.
// R8: Run bit starts counting at one, stops at zero, reads back.
// R9: Stopped count holds; restart continues from held value.
// R10: Run bit resets to zero.
// R11: Bits 3:2 select stopwatch interrupt level 0..3; 0 means none.
// R12: Level field resets to zero.
// R13: Bits 4,5,6 enable the 1, 10, 100 Hz interrupts.
// R14: Enables reset to zero.
// R15: Flags read one on event, cleared by writing one, reset zero.
// R16: 256 Hz divided to 100 Hz by alternating 2 and 3 tick gaps.
// R17: Flags set on falling edge of each rate, regardless of enables.
// R18: Request only when flag, enable set and level above CPU level.
// R19: Run/stop acts on next 256 Hz tick; run reads one until stopped.
// R20: Request presented with its level, held until flag or enable cleared or level no longer above CPU level.
module bsw_stopwatch #(
   parameter int TICK_DIV = bsw_pkg::TICK_CYCLES
) (
   input wire logic REF_CLK,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [15:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [1:0] CPU_LEVEL,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic IRQ_REQ,
   output logic [1:0] IRQ_LEVEL
);
   // ************************************************************
   // Bus decode
   // ************************************************************
   function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
      hit = (a[15:2] == r[15:2]);
   endfunction

   logic setup_w;
   logic wr_w;
   logic rd_w;
   logic wr_ctrl;
   logic wr_lvl;
   logic wr_en;
   logic wr_flag;
   logic mapped;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic [31:0] rd_nxt;

   // Zero-wait slave: access phase completes in its first cycle
   assign setup_w = PSEL && !PENABLE;
   assign wr_w = PSEL && PENABLE && PWRITE && pready_r;
   assign rd_w = setup_w && !PWRITE;
   // 0xff42 and 0xff43 share a word; control in lane 0, count in lane 1
   assign wr_ctrl = wr_w && hit(PADDR, bsw_pkg::ADDR_CONTROL);
   assign wr_lvl = wr_w && hit(PADDR, bsw_pkg::ADDR_LEVEL_SELECT);
   // Enables share the level word; lane 2 carries them, as the read mux shows
   assign wr_en = wr_w && hit(PADDR, bsw_pkg::ADDR_ENABLES);
   assign wr_flag = wr_w && hit(PADDR, bsw_pkg::ADDR_FLAGS);
   assign mapped = hit(PADDR, bsw_pkg::ADDR_LEVEL_SELECT) || hit(PADDR, bsw_pkg::ADDR_FLAGS)
      || hit(PADDR, bsw_pkg::ADDR_CONTROL);

   // ************************************************************
   // 256 Hz tick
   // ************************************************************
   logic [31:0] pre_r;
   logic tick;
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         pre_r <= 32'h0;
      end else if (pre_r == 32'(TICK_DIV - 1)) begin
         pre_r <= 32'h0;
      end else begin
         pre_r <= pre_r + 32'h1;
      end
   end
   assign tick = (pre_r == 32'(TICK_DIV - 1));

   // ************************************************************
   // Run control
   // ************************************************************
   logic run_req_r;
   logic running_r;
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         run_req_r <= 1'b0; // R10
      end else if (wr_ctrl) begin
         run_req_r <= PWDATA[bsw_pkg::RUN_BIT]; // R8
      end
   end
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         running_r <= 1'b0;
      end else if (tick) begin
         running_r <= run_req_r; // R19
      end
   end

   // ************************************************************
   // Divider and BCD counter
   // ************************************************************
   logic [1:0] div_r;
   logic alt_r;
   logic [3:0] hund_r;
   logic [3:0] tenth_r;
   logic clr;
   logic step;
   logic p100;
   logic p10;
   logic p1;
   assign clr = wr_ctrl && PWDATA[bsw_pkg::CLEAR_BIT]; // R4 R5
   assign step = tick && running_r; // R9
   // Divider pulse marks the falling edge of the 100 Hz signal
   assign p100 = step && (div_r == (alt_r ? bsw_pkg::DIV_LONG : bsw_pkg::DIV_SHORT) - 2'h1); // R16
   assign p10 = p100 && hund_r == bsw_pkg::BCD_MAX;
   assign p1 = p10 && tenth_r == bsw_pkg::BCD_MAX;

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         div_r <= 2'h0;
         alt_r <= 1'b0;
      end else if (clr) begin
         div_r <= 2'h0; // R6 R7
         alt_r <= 1'b0;
      end else if (p100) begin
         div_r <= 2'h0;
         alt_r <= !alt_r; // R16
      end else if (step) begin
         div_r <= div_r + 2'h1;
      end
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         hund_r <= bsw_pkg::COUNT_RESET[3:0]; // R3
         tenth_r <= bsw_pkg::COUNT_RESET[7:4];
      end else if (clr) begin
         hund_r <= 4'h0; // R4 R6 R7
         tenth_r <= 4'h0;
      end else if (p100) begin
         hund_r <= p10 ? 4'h0 : hund_r + 4'h1;
         if (p10) begin
            tenth_r <= p1 ? 4'h0 : tenth_r + 4'h1;
         end
      end
   end

   // ************************************************************
   // Level, enables, flags
   // ************************************************************
   logic [1:0] level_r;
   logic [2:0] en_r;
   logic [2:0] flag_r;
   logic [2:0] ev;
   logic [2:0] w1c;
   assign ev = {p100, p10, p1};
   assign w1c = wr_flag ? PWDATA[bsw_pkg::HUNDRED_HZ_BIT:bsw_pkg::ONE_HZ_BIT] : 3'h0;

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         level_r <= bsw_pkg::LEVEL_RESET; // R12
      end else if (wr_lvl) begin
         level_r <= PWDATA[bsw_pkg::LEVEL_HI:bsw_pkg::LEVEL_LO]; // R11
      end
   end
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         en_r <= bsw_pkg::ENABLE_RESET; // R14
      end else if (wr_en) begin
         en_r <= PWDATA[16 + bsw_pkg::HUNDRED_HZ_BIT:16 + bsw_pkg::ONE_HZ_BIT]; // R13
      end
   end
   // Set wins over a simultaneous clear so no event is lost
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         flag_r <= bsw_pkg::FLAG_RESET; // R15
      end else begin
         flag_r <= ev | (flag_r & ~w1c); // R15 R17
      end
   end

   // ************************************************************
   // Interrupt request
   // ************************************************************
   logic irq_r;
   logic [1:0] irq_lvl_r;
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         irq_r <= 1'b0;
         irq_lvl_r <= 2'h0;
      end else begin
         irq_r <= |(flag_r & en_r) && level_r > CPU_LEVEL; // R18 R20
         irq_lvl_r <= level_r; // R20
      end
   end
   assign IRQ_REQ = irq_r;
   assign IRQ_LEVEL = irq_lvl_r;

   // ************************************************************
   // Read mux and bus answer
   // ************************************************************
   always_comb begin
      rd_nxt = 32'h0;
      if (hit(PADDR, bsw_pkg::ADDR_LEVEL_SELECT)) begin
         rd_nxt[bsw_pkg::LEVEL_HI:bsw_pkg::LEVEL_LO] = level_r;
         rd_nxt[16 + bsw_pkg::HUNDRED_HZ_BIT:16 + bsw_pkg::ONE_HZ_BIT] = en_r;
      end else if (hit(PADDR, bsw_pkg::ADDR_FLAGS)) begin
         rd_nxt[bsw_pkg::HUNDRED_HZ_BIT:bsw_pkg::ONE_HZ_BIT] = flag_r;
      end else if (hit(PADDR, bsw_pkg::ADDR_CONTROL)) begin
         // Run reads one until counting has really stopped
         rd_nxt[bsw_pkg::RUN_BIT] = run_req_r || running_r; // R19
         rd_nxt[15:8] = {tenth_r, hund_r}; // R1 R2
      end
   end
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         prdata_r <= 32'h0;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= setup_w;
         pslverr_r <= setup_w && !mapped;
         if (rd_w) begin
            prdata_r <= rd_nxt;
         end
      end
   end
   assign PRDATA = prdata_r;
   assign PREADY = pready_r;
   assign PSLVERR = pslverr_r;

   // ************************************************************
   // Checks
   // ************************************************************
   a_count_write_ignored: assert property (@(posedge REF_CLK) disable iff (!NRST) // R2
      wr_w && hit(PADDR, bsw_pkg::ADDR_COUNT) && !clr && !p100 |=> $stable({tenth_r, hund_r}))
      else $error("count changed by write");

   a_clear_zeroes: assert property (@(posedge REF_CLK) disable iff (!NRST) // R4
      clr |=> hund_r == 4'h0 && tenth_r == 4'h0)
      else $error("clear failed");

   a_stopped_hold: assert property (@(posedge REF_CLK) disable iff (!NRST) // R9
      !running_r && !clr |=> $stable({tenth_r, hund_r}))
      else $error("count moved while stopped");

   a_run_on_tick: assert property (@(posedge REF_CLK) disable iff (!NRST) // R19
      !tick |=> running_r == $past(running_r))
      else $error("run changed off tick");

   a_bcd_range: assert property (@(posedge REF_CLK) disable iff (!NRST) // R1
      hund_r <= bsw_pkg::BCD_MAX && tenth_r <= bsw_pkg::BCD_MAX)
      else $error("digit out of BCD range");

   a_flag_set: assert property (@(posedge REF_CLK) disable iff (!NRST) // R17
      p10 |=> flag_r[1])
      else $error("10 Hz flag not set");

   a_flag_clear: assert property (@(posedge REF_CLK) disable iff (!NRST) // R15
      flag_r[0] && w1c[0] && !p1 |=> !flag_r[0])
      else $error("flag not cleared");

   a_irq_gate: assert property (@(posedge REF_CLK) disable iff (!NRST) // R18
      IRQ_REQ |-> $past(|(flag_r & en_r)) && $past(level_r) > $past(CPU_LEVEL))
      else $error("request without cause");

   a_div_gap: assert property (@(posedge REF_CLK) disable iff (!NRST) // R16
      p100 |-> div_r <= 2'h2)
      else $error("divider gap too long");

   // ************************************************************
   // Counter, register and request checks
   // ************************************************************
   a_hund_flag_set: assert property (@(posedge REF_CLK) disable iff (!NRST) // R17
      p100 |=> flag_r[2])
      else $error("100 Hz flag not set");

   a_one_flag_set: assert property (@(posedge REF_CLK) disable iff (!NRST) // R17
      p1 |=> flag_r[0])
      else $error("1 Hz flag not set");

   a_clear_reads_zero: assert property (@(posedge REF_CLK) disable iff (!NRST) // R5
      rd_nxt[bsw_pkg::CLEAR_BIT] == 1'b0)
      else $error("clear bit read as one");

   a_run_follows_req: assert property (@(posedge REF_CLK) disable iff (!NRST) // R19
      tick |=> running_r == $past(run_req_r))
      else $error("run not taken at tick");

   a_run_readback: assert property (@(posedge REF_CLK) disable iff (!NRST) // R8
      wr_ctrl |=> run_req_r == $past(PWDATA[bsw_pkg::RUN_BIT]))
      else $error("run bit not stored");

   a_level_write: assert property (@(posedge REF_CLK) disable iff (!NRST) // R11
      wr_lvl |=> level_r == $past(PWDATA[bsw_pkg::LEVEL_HI:bsw_pkg::LEVEL_LO]))
      else $error("level not stored");

   a_enable_write: assert property (@(posedge REF_CLK) disable iff (!NRST) // R13
      wr_en |=> en_r == $past(PWDATA[16 + bsw_pkg::HUNDRED_HZ_BIT:16 + bsw_pkg::ONE_HZ_BIT]))
      else $error("enables not stored");

   a_irq_level_out: assert property (@(posedge REF_CLK) disable iff (!NRST) // R20
      1'b1 |=> IRQ_LEVEL == $past(level_r))
      else $error("request level wrong");

   a_irq_needs_level: assert property (@(posedge REF_CLK) disable iff (!NRST) // R11
      IRQ_REQ |-> IRQ_LEVEL != 2'h0)
      else $error("request at level zero");

   a_irq_off_disabled: assert property (@(posedge REF_CLK) disable iff (!NRST) // R18
      (flag_r & en_r) == 3'h0 |=> !IRQ_REQ)
      else $error("request with no enabled flag");

   a_hund_step: assert property (@(posedge REF_CLK) disable iff (!NRST) // R1
      p100 && !p10 && !clr |=> hund_r == $past(hund_r) + 4'h1)
      else $error("hundredths did not step");

   a_tenth_step: assert property (@(posedge REF_CLK) disable iff (!NRST) // R1
      p10 && !p1 && !clr |=> tenth_r == $past(tenth_r) + 4'h1)
      else $error("tenths did not step");

   a_wrap_zero: assert property (@(posedge REF_CLK) disable iff (!NRST) // R1
      p1 && !clr |=> hund_r == 4'h0 && tenth_r == 4'h0)
      else $error("count did not wrap");

   a_div_short: assert property (@(posedge REF_CLK) disable iff (!NRST) // R16
      p100 && !alt_r |-> div_r == 2'h1)
      else $error("short gap wrong");

   a_div_long: assert property (@(posedge REF_CLK) disable iff (!NRST) // R16
      p100 && alt_r |-> div_r == 2'h2)
      else $error("long gap wrong");

   a_flag_hold: assert property (@(posedge REF_CLK) disable iff (!NRST) // R15
      ev == 3'h0 && w1c == 3'h0 |=> flag_r == $past(flag_r))
      else $error("flag changed without cause");
endmodule

/* File: dv/bsw_cpu_model.sv */
`timescale 1ns/1ps
// ************************************************************
// CPU side: current interrupt level and accepted requests
// ************************************************************
module bsw_cpu_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [1:0] level_cmd,
   input wire logic irq_req,
   output logic [1:0] cpu_level,
   output int taken
);
   // Level is registered, as the core updates it at an edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cpu_level <= 2'h0;
         taken <= 0;
      end else begin
         cpu_level <= level_cmd;
         if (irq_req === 1'b1) begin
            taken <= taken + 1;
         end
      end
   end
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq_req, err;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd, seed = 32'hacb57bad;
   logic [1:0] irq_level, cpu_level, level_cmd = 2'h0;
   int fails = 0, checked = 0, lv_m, en_m, c1, c2, taken;
   always #2.5 clk = ~clk;
   // Short tick divider keeps a full 1 Hz period near 1000 cycles
   bsw_stopwatch #(.TICK_DIV(4)) dut (.REF_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .CPU_LEVEL(cpu_level), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .IRQ_REQ(irq_req), .IRQ_LEVEL(irq_level));
   bsw_cpu_model cpu (.clk(clk), .nrst(nrst), .level_cmd(level_cmd), .irq_req(irq_req),
      .cpu_level(cpu_level), .taken(taken));
   // ************************************************************
   // Helpers
   // ************************************************************
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task complete_run;
      $display("fails=%0d checked=%0d", fails, checked);
      if (fails == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         fails++;
         $display("ERROR %0t: word %h expected %h", $time, g, e);
      end
   endtask
   task chk_irq(input logic g, input logic e);
      checked++;
      if (g !== e) begin
         fails++;
         $display("ERROR %0t: request %b expected %b", $time, g, e);
      end
   endtask
   task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         fails++;
         complete_run();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task cnt(output int v);
      apb(1'b0, bsw_pkg::ADDR_CONTROL, 32'h0);
      chk(rd[15:12] <= 4'h9 && rd[11:8] <= 4'h9, 32'h1);
      v = rd[15:12] * 10 + rd[11:8];
   endtask
   task stop_wait;
      int n;
      apb(1'b1, bsw_pkg::ADDR_CONTROL, 32'h0);
      n = 0;
      do begin
         apb(1'b0, bsw_pkg::ADDR_CONTROL, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 10);
      chk(rd[0], 32'h0);
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      fails++;
      complete_run();
   end
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      apb(1'b0, bsw_pkg::ADDR_LEVEL_SELECT, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, bsw_pkg::ADDR_FLAGS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, bsw_pkg::ADDR_CONTROL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 16'hff30, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      $display("reset test done");
      apb(1'b1, bsw_pkg::ADDR_CONTROL, 32'h1);
      repeat (400) @(posedge clk);
      stop_wait();
      cnt(c1);
      chk(c1 >= 37 && c1 <= 44, 32'h1);
      repeat (100) @(posedge clk);
      apb(1'b1, bsw_pkg::ADDR_CONTROL, (rnd() & 32'hff) << 8);
      cnt(c2);
      chk(c2, c1);
      chk(rd[1], 32'h0);
      apb(1'b1, bsw_pkg::ADDR_CONTROL, 32'h1);
      repeat (50) @(posedge clk);
      stop_wait();
      cnt(c2);
      chk(c2 > c1 && c2 < c1 + 10, 32'h1);
      apb(1'b1, bsw_pkg::ADDR_CONTROL, 32'h2);
      cnt(c1);
      chk(c1, 32'h0);
      repeat (100) @(posedge clk);
      cnt(c1);
      chk(c1, 32'h0);
      $display("count test done");
      apb(1'b1, bsw_pkg::ADDR_CONTROL, 32'h1);
      repeat (200) @(posedge clk);
      apb(1'b1, bsw_pkg::ADDR_CONTROL, 32'h3);
      cnt(c1);
      chk(c1 < 3, 32'h1);
      repeat (1100) @(posedge clk);
      stop_wait();
      apb(1'b0, bsw_pkg::ADDR_FLAGS, 32'h0);
      chk(rd, 32'h70);
      chk_irq(irq_req, 1'b0);
      $display("flag test done");
      // Flags stay frozen while stopped, so the request is a pure function
      for (int i = 0; i < 16; i++) begin
         lv_m = i % 4;
         en_m = rnd() & 7;
         level_cmd <= 2'(i / 4);
         apb(1'b1, bsw_pkg::ADDR_LEVEL_SELECT, (en_m << 20) | (lv_m << 2));
         repeat (3) @(posedge clk);
         chk_irq(irq_req, en_m != 0 && lv_m > i / 4);
         if (en_m != 0 && lv_m > i / 4) chk(irq_level, lv_m);
         apb(1'b0, bsw_pkg::ADDR_LEVEL_SELECT, 32'h0);
         chk(rd, (en_m << 20) | (lv_m << 2));
      end
      level_cmd <= 2'h0;
      apb(1'b1, bsw_pkg::ADDR_LEVEL_SELECT, 32'h0070_000c);
      apb(1'b1, bsw_pkg::ADDR_FLAGS, 32'h0);
      chk_irq(irq_req, 1'b1);
      apb(1'b0, bsw_pkg::ADDR_FLAGS, 32'h0);
      chk(rd, 32'h70);
      apb(1'b1, bsw_pkg::ADDR_FLAGS, 32'h10);
      apb(1'b0, bsw_pkg::ADDR_FLAGS, 32'h0);
      chk(rd, 32'h60);
      apb(1'b1, bsw_pkg::ADDR_FLAGS, 32'h60);
      apb(1'b0, bsw_pkg::ADDR_FLAGS, 32'h0);
      chk(rd, 32'h0);
      repeat (3) @(posedge clk);
      chk_irq(irq_req, 1'b0);
      $display("interrupt test done");
      complete_run();
   end
endmodule
